// ### rtl/pbwg_pkg.sv
package pbwg_pkg;

  // ---------------------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------------------
  localparam int CPU_AW   = 8;
  localparam int CPU_DW   = 8;
  localparam int WB_AW    = 6;
  localparam int WB_DW    = 32;
  localparam int WAIT_W   = 4;
  localparam int DIV_W    = 3;
  localparam int TOTAL_W  = 16;
  localparam int EVCNT_W  = 16;

  // ---------------------------------------------------------------------------
  // Peripheral register addresses on the CPU side
  // ---------------------------------------------------------------------------
  localparam logic [CPU_AW-1:0] ADDR_WATCHDOG_MODE  = 8'h21;
  localparam logic [CPU_AW-1:0] ADDR_SERIAL_A_RXST  = 8'h31;
  localparam logic [CPU_AW-1:0] ADDR_SERIAL_B_RXST  = 8'h41;
  localparam logic [CPU_AW-1:0] ADDR_CONV_MODE      = 8'h50;
  localparam logic [CPU_AW-1:0] ADDR_CONV_CHANNEL   = 8'h51;
  localparam logic [CPU_AW-1:0] ADDR_PF_COMPARE     = 8'h52;
  localparam logic [CPU_AW-1:0] ADDR_PF_THRESHOLD   = 8'h53;
  localparam logic [CPU_AW-1:0] ADDR_CONV_RESULT    = 8'h54;

  // Position of the conversion-time bit inside the converter mode register.
  localparam int CONV_TIME_BIT_POS = 5;

  // ---------------------------------------------------------------------------
  // Wait counts in CPU clocks and converter macro clock in oscillator periods
  // ---------------------------------------------------------------------------
  localparam logic [WAIT_W-1:0] WATCHDOG_WAIT  = 4'h3;
  localparam logic [WAIT_W-1:0] SERIAL_WAIT    = 4'h1;
  localparam logic [WAIT_W-1:0] NO_WAIT        = 4'h0;
  localparam int                MACRO_DIV_FAST = 2;
  localparam int                MACRO_DIV_SLOW = 4;
  localparam int                DIV_SEL_MAX    = 4;

  // ---------------------------------------------------------------------------
  // Wishbone register byte offsets and fields
  // ---------------------------------------------------------------------------
  localparam logic [WB_AW-1:0] OFS_CTRL   = 6'h00;
  localparam logic [WB_AW-1:0] OFS_STATUS = 6'h04;
  localparam logic [WB_AW-1:0] OFS_TOTAL  = 6'h08;
  localparam logic [WB_AW-1:0] OFS_EVBASE = 6'h10;

  localparam int CTRL_DIV_LSB     = 0;
  localparam int STAT_CONV_POS    = 0;
  localparam int STAT_BUSY_POS    = 1;
  localparam int STAT_CALC_LSB    = 4;
  localparam int STAT_LAST_LSB    = 8;

  localparam logic [DIV_W-1:0] CTRL_DIV_RST  = 3'h0;
  localparam logic             CONV_TIME_RST = 1'b0;

  // ---------------------------------------------------------------------------
  // Access classes
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    CLS_WATCHDOG,
    CLS_SERIAL,
    CLS_CONV_WRITE,
    CLS_CONV_READ,
    CLS_OTHER
  } pbwg_class_e;

  localparam int NUM_CLASS = 5;

  typedef struct packed {
    logic [CPU_AW-1:0] addr;
    logic              we;
    logic [CPU_DW-1:0] wdata;
  } pbwg_cpu_req_s;

endpackage

// ### rtl/pbwg_conv_wait.sv
module pbwg_conv_wait
  import pbwg_pkg::*;
(
  input  wire logic              convTimeBit,
  input  wire logic [DIV_W-1:0]  cpuDivSel,
  output logic      [WAIT_W-1:0] convWait
);

  logic [2:0] divEff;
  logic [4:0] numer;
  logic [4:0] denom;
  logic [4:0] quot;
  logic [4:0] remd;
  logic       roundUp;

  // ---------------------------------------------------------------------------
  // Converter wait: two macro periods over one CPU period, plus one
  // ---------------------------------------------------------------------------
  always_comb
  begin
    divEff = (cpuDivSel > 3'(DIV_SEL_MAX)) ? 3'(DIV_SEL_MAX) : cpuDivSel;
    // Both periods are counted in main oscillator periods.
    numer  = convTimeBit ? 5'(2 * MACRO_DIV_FAST) : 5'(2 * MACRO_DIV_SLOW);
    denom  = 5'h01 << divEff;
    quot   = numer >> divEff;
    remd   = numer & (denom - 5'h01);
    // A remainder beyond the CPU clock low width (half a period) rounds up.
    roundUp  = {remd, 1'b0} > {1'b0, denom};
    convWait = WAIT_W'(quot + 5'(roundUp) + 5'h01);
  end

endmodule

// ### rtl/pbwg_top.sv
// The implementer's own choices: the Wishbone slave port and the register addresses.
module pbwg_top
  import pbwg_pkg::*;
(
  input  wire logic                          sys_clk,
  input  wire logic                          sys_rst,
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [pbwg_pkg::WB_AW-1:0]    wb_adr_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic [pbwg_pkg::WB_DW-1:0]    wb_dat_i,
  output logic      [pbwg_pkg::WB_DW-1:0]    wb_dat_o,
  output logic                               wb_ack_o,
  input  wire logic                          cpuStart,
  input  wire pbwg_pkg::pbwg_cpu_req_s       cpuReq,
  output logic                               cpuHold,
  output logic                               cpuDone,
  output logic      [pbwg_pkg::CPU_DW-1:0]   cpuRdata,
  output logic                               periphSel,
  output pbwg_pkg::pbwg_cpu_req_s            periphReq,
  input  wire logic [pbwg_pkg::CPU_DW-1:0]   periphRdata
);

  import pbwg_pkg::*;

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  logic                ackQ;
  logic [WB_DW-1:0]    datQ;
  logic [DIV_W-1:0]    divSelQ;
  logic                convTimeQ;
  logic                busyQ;
  logic [WAIT_W-1:0]   waitCntQ;
  logic [WAIT_W-1:0]   lastWaitQ;
  pbwg_cpu_req_s       reqQ;
  logic [CPU_DW-1:0]   rdataQ;
  logic                doneQ;
  logic [TOTAL_W-1:0]  totalQ;
  logic [WAIT_W-1:0]   convWait;
  logic [WAIT_W-1:0]   waitNeed;
  pbwg_class_e         accClass;
  logic                accept;
  logic                finish;
  logic                stallTick;
  logic                wbReq;
  logic                wbWrite;
  logic                totalClr;
  logic [WB_DW-1:0]    rdMux;
  logic [EVCNT_W-1:0]  evCnt [NUM_CLASS];
  logic [NUM_CLASS-1:0] evClr;

  // ---------------------------------------------------------------------------
  // Converter wait calculation
  // ---------------------------------------------------------------------------
  pbwg_conv_wait u_conv_wait (
    .convTimeBit (convTimeQ),
    .cpuDivSel   (divSelQ),
    .convWait    (convWait)
  );

  // ---------------------------------------------------------------------------
  // Access classification and wait count
  // ---------------------------------------------------------------------------
  always_comb
  begin
    accClass = CLS_OTHER;
    waitNeed = NO_WAIT;
    case (cpuReq.addr)
      ADDR_WATCHDOG_MODE:
      begin
        if (cpuReq.we)
        begin
          accClass = CLS_WATCHDOG;
          waitNeed = WATCHDOG_WAIT;
        end
      end
      ADDR_SERIAL_A_RXST, ADDR_SERIAL_B_RXST:
      begin
        if (!cpuReq.we)
        begin
          accClass = CLS_SERIAL;
          waitNeed = SERIAL_WAIT;
        end
      end
      ADDR_CONV_MODE, ADDR_CONV_CHANNEL, ADDR_PF_COMPARE, ADDR_PF_THRESHOLD:
      begin
        if (cpuReq.we)
        begin
          accClass = CLS_CONV_WRITE;
          // A computed count of one means the write needs no wait at all.
          waitNeed = (convWait == 4'h1) ? NO_WAIT : convWait;
        end
      end
      ADDR_CONV_RESULT:
      begin
        if (!cpuReq.we)
        begin
          accClass = CLS_CONV_READ;
          waitNeed = convWait;
        end
      end
      default:
      begin
        accClass = CLS_OTHER;
        waitNeed = NO_WAIT;
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // Access sequencing
  // ---------------------------------------------------------------------------
  // A new access is only taken once the previous one has fully completed.
  assign accept    = cpuStart && !busyQ;
  assign finish    = busyQ && (waitCntQ == NO_WAIT);
  assign stallTick = busyQ && (waitCntQ != NO_WAIT);

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      busyQ <= 1'b0;
    end
    else if (accept)
    begin
      busyQ <= 1'b1;
    end
    else if (finish)
    begin
      busyQ <= 1'b0;
    end
  end

  // Each stall cycle is one CPU clock, so the real time follows the divider.
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      waitCntQ <= NO_WAIT;
    end
    else if (accept)
    begin
      waitCntQ <= waitNeed;
    end
    else if (stallTick)
    begin
      waitCntQ <= waitCntQ - 4'h1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      reqQ <= '0;
    end
    else if (accept)
    begin
      reqQ <= cpuReq;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      lastWaitQ <= NO_WAIT;
    end
    else if (accept)
    begin
      lastWaitQ <= waitNeed;
    end
  end

  // Read data is only taken after the full wait, when it has settled.
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      rdataQ <= '0;
      doneQ  <= 1'b0;
    end
    else
    begin
      doneQ <= finish;
      if (finish && !reqQ.we)
      begin
        rdataQ <= periphRdata;
      end
    end
  end

  // The conversion-time bit is snooped from CPU writes to the mode register.
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      convTimeQ <= CONV_TIME_RST;
    end
    else if (accept && cpuReq.we && (cpuReq.addr == ADDR_CONV_MODE))
    begin
      convTimeQ <= cpuReq.wdata[CONV_TIME_BIT_POS];
    end
  end

  assign cpuHold   = stallTick;
  assign cpuDone   = doneQ;
  assign cpuRdata  = rdataQ;
  assign periphSel = busyQ;
  assign periphReq = reqQ;

  // ---------------------------------------------------------------------------
  // Wishbone slave
  // ---------------------------------------------------------------------------
  assign wbReq    = wb_cyc_i && wb_stb_i;
  assign wbWrite  = wbReq && wb_we_i && ackQ;
  assign totalClr = wbWrite && (wb_adr_i == OFS_TOTAL) && (wb_sel_i != 4'h0);

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      ackQ <= 1'b0;
    end
    else
    begin
      ackQ <= wbReq && !ackQ;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      divSelQ <= CTRL_DIV_RST;
    end
    else if (wbWrite && (wb_adr_i == OFS_CTRL) && wb_sel_i[0])
    begin
      divSelQ <= wb_dat_i[CTRL_DIV_LSB +: DIV_W];
    end
  end

  // A stall cycle in the same cycle as a clear is kept.
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      totalQ <= '0;
    end
    else if (totalClr)
    begin
      totalQ <= TOTAL_W'(stallTick);
    end
    else if (stallTick && (totalQ != '1))
    begin
      totalQ <= totalQ + 16'h0001;
    end
  end

  // ---------------------------------------------------------------------------
  // Per-class access counters
  // ---------------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CLASS; gi++)
    begin : g_ev
      logic hit;
      assign hit       = accept && (accClass == pbwg_class_e'(gi));
      assign evClr[gi] = wbWrite && (wb_sel_i != 4'h0) &&
                         (wb_adr_i == WB_AW'(OFS_EVBASE + 6'(4 * gi)));
      always_ff @(posedge sys_clk)
      begin
        if (sys_rst)
        begin
          evCnt[gi] <= '0;
        end
        else if (evClr[gi])
        begin
          evCnt[gi] <= EVCNT_W'(hit);
        end
        else if (hit && (evCnt[gi] != '1))
        begin
          evCnt[gi] <= evCnt[gi] + 16'h0001;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Read multiplexer
  // ---------------------------------------------------------------------------
  always_comb
  begin
    rdMux = '0;
    case (wb_adr_i)
      OFS_CTRL:
      begin
        rdMux[CTRL_DIV_LSB +: DIV_W] = divSelQ;
      end
      OFS_STATUS:
      begin
        rdMux[STAT_CONV_POS]                 = convTimeQ;
        rdMux[STAT_BUSY_POS]                 = busyQ;
        rdMux[STAT_CALC_LSB +: WAIT_W]       = convWait;
        rdMux[STAT_LAST_LSB +: WAIT_W]       = lastWaitQ;
      end
      OFS_TOTAL:
      begin
        rdMux[TOTAL_W-1:0] = totalQ;
      end
      default:
      begin
        for (int i = 0; i < NUM_CLASS; i++)
        begin
          if (wb_adr_i == WB_AW'(OFS_EVBASE + 6'(4 * i)))
          begin
            rdMux[EVCNT_W-1:0] = evCnt[i];
          end
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      datQ <= '0;
    end
    else if (wbReq && !ackQ && !wb_we_i)
    begin
      datQ <= rdMux;
    end
  end

  assign wb_ack_o = ackQ;
  assign wb_dat_o = datQ;

endmodule

// ### verification/pbwg_top_properties.sv
// ----------------------------------------
// Access wait timing and bus ack checks at the top ports
// ----------------------------------------
module pbwg_top_checker
  import pbwg_pkg::*;
(
  input wire logic                        sys_clk,
  input wire logic                        sys_rst,
  input wire logic                        wb_cyc_i,
  input wire logic                        wb_stb_i,
  input wire logic                        wb_we_i,
  input wire logic [pbwg_pkg::WB_AW-1:0]  wb_adr_i,
  input wire logic [3:0]                  wb_sel_i,
  input wire logic [pbwg_pkg::WB_DW-1:0]  wb_dat_i,
  input wire logic [pbwg_pkg::WB_DW-1:0]  wb_dat_o,
  input wire logic                        wb_ack_o,
  input wire logic                        cpuStart,
  input wire pbwg_pkg::pbwg_cpu_req_s     cpuReq,
  input wire logic                        cpuHold,
  input wire logic                        cpuDone,
  input wire logic [pbwg_pkg::CPU_DW-1:0] cpuRdata,
  input wire logic                        periphSel,
  input wire pbwg_pkg::pbwg_cpu_req_s     periphReq,
  input wire logic [pbwg_pkg::CPU_DW-1:0] periphRdata
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  logic       take;
  logic [7:0] ad;
  assign take = cpuStart && !periphSel;
  assign ad   = cpuReq.addr;

  a_hold_in_access: assert property (cpuHold |-> periphSel)
    else $error("hold outside an access");
  a_done_on_release: assert property ($fell(periphSel) |-> cpuDone)
    else $error("access ended without done");
  a_done_idle: assert property (cpuDone |-> !periphSel && !cpuHold)
    else $error("done while still busy");
  a_req_latched: assert property (take |=> periphSel && periphReq == $past(cpuReq))
    else $error("request not latched");
  a_watchdog_three: assert property (take && ad == ADDR_WATCHDOG_MODE && cpuReq.we
    |=> cpuHold [*3] ##1 !cpuHold ##1 cpuDone) else $error("watchdog write wait wrong");
  a_serial_one: assert property (take && !cpuReq.we
    && (ad == ADDR_SERIAL_A_RXST || ad == ADDR_SERIAL_B_RXST)
    |=> cpuHold ##1 !cpuHold ##1 cpuDone) else $error("serial read wait wrong");
  a_other_none: assert property (take && !(ad inside {8'h21, 8'h31, 8'h41, [8'h50:8'h54]})
    |=> !cpuHold ##1 cpuDone) else $error("unlisted register waited");
  a_conv_bound: assert property (take && ad inside {[8'h50:8'h54]} |=> ##[1:10] cpuDone)
    else $error("converter wait too long");
  a_ack_pulse: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single pulse");

  c_watchdog: cover property (take && ad == ADDR_WATCHDOG_MODE && cpuReq.we);
  c_result: cover property (take && ad == ADDR_CONV_RESULT);
  c_long_hold: cover property (cpuHold [*8]);
endmodule

// ### verification/pbwg_periph_model.sv
// ----------------------------------------
// Slow peripheral register side
// ----------------------------------------
module pbwg_periph_model
  import pbwg_pkg::*;
(
  input wire logic                         sys_clk,
  input wire logic                         periphSel,
  input wire pbwg_pkg::pbwg_cpu_req_s      periphReq,
  output logic      [pbwg_pkg::CPU_DW-1:0] periphRdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [CPU_DW-1:0] lastQ = 8'h00;
  // Released data toggles every cycle so a sample one cycle late never matches.
  always_comb periphRdata = periphSel ? (periphReq.addr ^ 8'h5a) : ~lastQ;
  always_ff @(posedge sys_clk) lastQ <= periphRdata;
endmodule

// ### verification/pbwg_top_bench.sv
`define CHK(what, exp, got) \
  begin samples_checked++; if ((got) !== (exp)) begin failures++; \
  $display("ERROR %s expected %0h seen %0h", what, exp, got); end end
module pbwg_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import pbwg_pkg::*;
  logic              sys_clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [WB_AW-1:0]  wb_adr_i;
  logic [3:0]        wb_sel_i;
  logic [WB_DW-1:0]  wb_dat_i, wb_dat_o, q;
  logic              cpuStart, cpuHold, cpuDone, periphSel;
  pbwg_cpu_req_s     cpuReq, periphReq;
  logic [CPU_DW-1:0] cpuRdata, periphRdata;
  logic [3:0]        w;
  int                failures, samples_checked;
  int                convTab [2][5] = '{'{9, 5, 3, 2, 1}, '{5, 3, 2, 1, 1}};
  logic [WB_DW-1:0]  evExp [NUM_CLASS] = '{32'h1, 32'h2, 32'h0, 32'h0, 32'h3};

  pbwg_top i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cpuStart(cpuStart),
    .cpuReq(cpuReq), .cpuHold(cpuHold), .cpuDone(cpuDone), .cpuRdata(cpuRdata),
    .periphSel(periphSel), .periphReq(periphReq), .periphRdata(periphRdata));
  pbwg_periph_model i_model (.sys_clk(sys_clk), .periphSel(periphSel),
    .periphReq(periphReq), .periphRdata(periphRdata));

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic end_of_test;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic timed_out;
    failures++;
    $display("ERROR handshake expected answer seen none");
    end_of_test();
  endtask

  task automatic wb_acc(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int k;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= wr;
    wb_sel_i <= 4'hf;
    wb_adr_i <= a;
    wb_dat_i <= d;
    for (k = 0; k < 20; k++)
    begin
      @(posedge sys_clk);
      if (wb_ack_o === 1'b1) break;
    end
    if (k == 20) timed_out();
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic cpu_acc(input logic [7:0] a, input logic wr, input logic [7:0] d,
                         input logic [3:0] expW);
    logic [3:0] n;
    int         k;
    n = 4'h0;
    cpuStart <= 1'b1;
    cpuReq   <= '{addr: a, we: wr, wdata: d};
    @(posedge sys_clk);
    cpuStart <= 1'b0;
    for (k = 0; k < 30; k++)
    begin
      @(posedge sys_clk);
      if (cpuDone === 1'b1) break;
      if (cpuHold === 1'b1) n++;
    end
    if (k == 30) timed_out();
    `CHK("wait clocks", expW, n)
    if (!wr) `CHK("read data", a ^ 8'h5a, cpuRdata)
  endtask

  initial
  begin
    sys_rst  = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i  = 1'b0;
    wb_adr_i = '0;
    wb_sel_i = 4'hf;
    wb_dat_i = '0;
    cpuStart = 1'b0;
    cpuReq   = '0;
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    wb_acc(1'b0, OFS_CTRL, 32'h0);
    `CHK("ctrl reset", 32'h0, q)
    wb_acc(1'b0, OFS_STATUS, 32'h0);
    `CHK("status reset", 32'h90, q)
    wb_acc(1'b0, 6'h3c, 32'h0);
    `CHK("unmapped read", 32'h0, q)
    wb_acc(1'b1, OFS_TOTAL, 32'h0);
    cpu_acc(ADDR_WATCHDOG_MODE, 1'b1, 8'h07, 4'h3);
    cpu_acc(ADDR_SERIAL_A_RXST, 1'b0, 8'h00, 4'h1);
    cpu_acc(ADDR_SERIAL_B_RXST, 1'b0, 8'h00, 4'h1);
    cpu_acc(ADDR_WATCHDOG_MODE, 1'b0, 8'h00, 4'h0);
    cpu_acc(8'h60, 1'b1, 8'h11, 4'h0);
    cpu_acc(8'h61, 1'b0, 8'h00, 4'h0);
    wb_acc(1'b0, OFS_TOTAL, 32'h0);
    `CHK("total wait", 32'h5, q)
    for (int i = 0; i < NUM_CLASS; i++)
    begin
      wb_acc(1'b0, OFS_EVBASE + 6'(4 * i), 32'h0);
      `CHK("class count", evExp[i], q)
    end
    for (int c = 0; c < 2; c++)
    begin
      wb_acc(1'b1, OFS_CTRL, 32'h0);
      cpu_acc(ADDR_CONV_MODE, 1'b1, (c == 1) ? 8'h20 : 8'h00, 4'h9);
      for (int d = 0; d < 5; d++)
      begin
        w = 4'(convTab[c][d]);
        wb_acc(1'b1, OFS_CTRL, 32'(d));
        wb_acc(1'b0, OFS_STATUS, 32'h0);
        `CHK("calc wait", w, q[7:4])
        `CHK("conv bit", 1'(c), q[0])
        cpu_acc(8'(ADDR_CONV_CHANNEL + d % 3), 1'b1, 8'h01, (w == 4'h1) ? 4'h0 : w);
        cpu_acc(ADDR_CONV_RESULT, 1'b0, 8'h00, w);
      end
    end
    wb_acc(1'b1, OFS_CTRL, 32'h7);
    wb_acc(1'b0, OFS_STATUS, 32'h0);
    `CHK("clamped wait", 4'h1, q[7:4])
    `CHK("last wait", 4'h1, q[11:8])
    end_of_test();
  end
endmodule
bind pbwg_top pbwg_top_checker i_checker (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .cpuStart(cpuStart), .cpuReq(cpuReq), .cpuHold(cpuHold), .cpuDone(cpuDone),
  .cpuRdata(cpuRdata), .periphSel(periphSel), .periphReq(periphReq),
  .periphRdata(periphRdata));
